// *** rtl/lcd_pkg.sv ***
// Constants shared by the display memory addressing and panel scan block.
package lcd_pkg;
  // Geometry.
  localparam int NUM_COLS = 102;
  localparam int NUM_COMS = 54;
  localparam int NUM_LINES = 55;
  localparam int MEM_DEPTH = 1152;
  localparam logic [6:0] COL_LAST = 7'h65;
  localparam logic [3:0] PAGE_LAST = 4'h7;
  localparam logic [3:0] PAGE_IND = 4'h8;
  localparam logic [5:0] LINE_IND = 6'h36;
  // Register offsets.
  localparam logic [3:0] OFS_CTRL = 4'h0;
  localparam logic [3:0] OFS_PAGE = 4'h1;
  localparam logic [3:0] OFS_COL = 4'h2;
  localparam logic [3:0] OFS_START = 4'h3;
  localparam logic [3:0] OFS_DATA = 4'h4;
  localparam logic [3:0] OFS_POWER = 4'h5;
  localparam logic [3:0] OFS_CONTRAST = 4'h6;
  localparam logic [3:0] OFS_RATIO = 4'h7;
  localparam logic [3:0] OFS_STATUS = 4'h8;
  // Control register field positions.
  localparam int CTRL_SEG_REV = 0;
  localparam int CTRL_COM_REV = 1;
  localparam int CTRL_DISP_ON = 2;
  localparam int CTRL_INVERSE = 3;
  localparam int CTRL_ALL_ON = 4;
  localparam int CTRL_PSAVE = 5;
  // Power control field positions.
  localparam int PWR_BOOST = 2;
  localparam int PWR_REGUL = 1;
  localparam int PWR_FOLLOW = 0;
  // Reset values, contrast maximum and external ratio code.
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [5:0] START_RST = 6'h00;
  localparam logic [2:0] POWER_RST = 3'h0;
  localparam logic [4:0] CONTRAST_RST = 5'h00;
  localparam logic [2:0] RATIO_RST = 3'h0;
  localparam logic [4:0] CONTRAST_MAX = 5'h1F;
  localparam logic [2:0] RATIO_EXT = 3'h7;
  // Drive level codes.
  localparam int DRV_W = 2;
  localparam logic [1:0] DRV_VSS = 2'h0;
  localparam logic [1:0] DRV_HI = 2'h1;
  localparam logic [1:0] DRV_MIDA = 2'h2;
  localparam logic [1:0] DRV_MIDB = 2'h3;
  // Timing.
  localparam int CLK_PERIOD_NS = 4;
  localparam int OSC_PERIOD_NS = 64;
  localparam int OSC_DIV_CYC = OSC_PERIOD_NS / CLK_PERIOD_NS;
  localparam int EXT_HOLD_NS = 10000;
  localparam int EXT_HOLD_CYC = EXT_HOLD_NS / CLK_PERIOD_NS;
  localparam logic [3:0] INT_TICKS_LAST = 4'h7;
  localparam logic [3:0] EXT_TICKS_LAST = 4'hF;
endpackage

// *** rtl/lcd_drv_cell.sv ***
// One panel output driver that picks one of four drive levels.
`timescale 1ns/100ps
`default_nettype none
module lcd_drv_cell #(
  parameter bit IS_COM = 1'b0
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Selection
  input wire logic sel,
  input wire logic fr,
  input wire logic psave,
  // Drive level
  output logic [lcd_pkg::DRV_W-1:0] level
);
  import lcd_pkg::*;

  logic [1:0] level_reg, level_next;

  always_comb begin
    if (psave) begin
      level_next = DRV_VSS;
    end else if (IS_COM) begin
      level_next = sel ? (fr ? DRV_VSS : DRV_HI) : (fr ? DRV_MIDA : DRV_MIDB);
    end else begin
      level_next = sel ? (fr ? DRV_HI : DRV_VSS) : (fr ? DRV_MIDA : DRV_MIDB);
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      level_reg <= DRV_VSS;
    end else begin
      level_reg <= level_next;
    end
  end

  assign level = level_reg;

  property p_level_select;
    @(posedge mclk) disable iff (rst)
    !psave && !sel |=> level == ($past(fr) ? DRV_MIDA : DRV_MIDB);
  endproperty
  a_level_select: assert property (p_level_select) else $error("drive level wrong");
endmodule
`default_nettype wire

// *** rtl/lcd_scan.sv ***
// Display memory addressing, register port and panel scan timing.
//
// Chosen here: the plain strobed port and the address map.
`timescale 1ns/100ps
`default_nettype none
// What this block does
// - Column advances by one per data access.
// - Column 65H wraps to zero, page advances.
// - Last page and column wrap both to zero.
// - Page eight holds indicator, only bit zero.
// - Segment direction mirrors column to output mapping.
// - Start line picks first scanned memory line.
// - Common direction maps start line to 0/53.
// - Scanned lines ascend from start, wrapping at 3FH.
// - Display modifiers act only on latched data.
// - Memory is 102 columns by 65 rows.
// - Oscillator runs when select high, not saving.
// - Select low stops clock; toggling means external.
// - Frame is oscillator/(55*8) or external/(55*16).
// - Timing drives line counter, latch, commons, frame.
// - Each driver picks one of four levels.
// - Three power bits: booster, regulator, follower.
// - Contrast has 32 levels set by command.
// - Contrast factor equals 31 minus code.
// - Ratio code 7 selects external divider.
module lcd_scan #(
  parameter int OSC_DIV = lcd_pkg::OSC_DIV_CYC,
  parameter int EXT_HOLD = lcd_pkg::EXT_HOLD_CYC
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Register port
  input wire logic [3:0] host_addr,
  input wire logic [7:0] host_wdata,
  input wire logic host_wr,
  input wire logic host_rd,
  output logic [7:0] host_rdata,
  // Display clock pin
  input wire logic display_clock_select,
  // Panel drive
  output logic [lcd_pkg::NUM_COLS*lcd_pkg::DRV_W-1:0] segment_outputs,
  output logic [lcd_pkg::NUM_COMS*lcd_pkg::DRV_W-1:0] common_outputs,
  output logic [lcd_pkg::DRV_W-1:0] indicator_common,
  output logic frame_alternating_signal,
  // Power and contrast settings
  output logic booster_en,
  output logic regulator_en,
  output logic follower_en,
  output logic [4:0] contrast_code,
  output logic [4:0] contrast_factor,
  output logic [2:0] ratio_sel,
  output logic ratio_external
);
  import lcd_pkg::*;

  ////////////////////////////////////////////////////////////////////////////////
  // Registers and address counters.
  logic [7:0] ctrl_reg, ctrl_next;
  logic [3:0] page_reg, page_next;
  logic [6:0] col_reg, col_next;
  logic [5:0] start_reg, start_next;
  logic [2:0] pwr_reg, pwr_next, ratio_reg, ratio_next;
  logic [4:0] con_reg, con_next, fac_reg, fac_next;
  logic rext_reg, rext_next;
  logic [7:0] rdata_reg, rdata_next, rd_mux;
  logic acc;
  logic [7:0] mem [0:MEM_DEPTH-1];
  logic fr_reg, ext_act;
  logic [5:0] scan_reg;

  assign acc = (host_wr | host_rd) && host_addr == OFS_DATA;

  always_comb begin
    ctrl_next = ctrl_reg;
    page_next = page_reg;
    col_next = col_reg;
    start_next = start_reg;
    pwr_next = pwr_reg;
    con_next = con_reg;
    fac_next = fac_reg;
    ratio_next = ratio_reg;
    rext_next = rext_reg;
    if (host_wr) begin
      case (host_addr)
        OFS_CTRL: ctrl_next = host_wdata;
        OFS_PAGE: begin
          // Pages above the indicator page would address nothing, so they are dropped.
          if (host_wdata <= {4'h0, PAGE_IND}) begin
            page_next = host_wdata[3:0];
          end
        end
        OFS_COL: begin
          if (host_wdata <= {1'b0, COL_LAST}) begin
            col_next = host_wdata[6:0];
          end
        end
        OFS_START: start_next = host_wdata[5:0];
        OFS_POWER: pwr_next = host_wdata[2:0];
        OFS_CONTRAST: begin
          con_next = host_wdata[4:0];
          fac_next = CONTRAST_MAX - host_wdata[4:0];
        end
        OFS_RATIO: begin
          ratio_next = host_wdata[2:0];
          rext_next = host_wdata[2:0] == RATIO_EXT;
        end
        default: begin
        end
      endcase
    end
    if (acc) begin
      if (col_reg == COL_LAST) begin
        col_next = 7'h00;
        // The indicator page is never reached by stepping, nor left towards page 9.
        page_next = (page_reg < PAGE_LAST) ? page_reg + 4'h1 : 4'h0;
      end else begin
        col_next = col_reg + 7'h01;
      end
    end
  end

  always_comb begin
    case (host_addr)
      OFS_CTRL: rd_mux = ctrl_reg;
      OFS_PAGE: rd_mux = {4'h0, page_reg};
      OFS_COL: rd_mux = {1'b0, col_reg};
      OFS_START: rd_mux = {2'h0, start_reg};
      OFS_POWER: rd_mux = {5'h00, pwr_reg};
      OFS_CONTRAST: rd_mux = {3'h0, con_reg};
      OFS_RATIO: rd_mux = {5'h00, ratio_reg};
      OFS_STATUS: rd_mux = {fr_reg, ext_act, scan_reg};
      default: rd_mux = 8'h00;
    endcase
    rdata_next = 8'h00;
    if (host_rd) begin
      rdata_next = (host_addr == OFS_DATA) ? mem[{page_reg, col_reg}] : rd_mux;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      ctrl_reg <= CTRL_RST;
      page_reg <= 4'h0;
      col_reg <= 7'h00;
      start_reg <= START_RST;
      pwr_reg <= POWER_RST;
      con_reg <= CONTRAST_RST;
      fac_reg <= CONTRAST_MAX;
      ratio_reg <= RATIO_RST;
      rext_reg <= 1'b0;
      rdata_reg <= 8'h00;
    end else begin
      ctrl_reg <= ctrl_next;
      page_reg <= page_next;
      col_reg <= col_next;
      start_reg <= start_next;
      pwr_reg <= pwr_next;
      con_reg <= con_next;
      fac_reg <= fac_next;
      ratio_reg <= ratio_next;
      rext_reg <= rext_next;
      rdata_reg <= rdata_next;
    end
  end

  assign host_rdata = rdata_reg;
  assign booster_en = pwr_reg[PWR_BOOST];
  assign regulator_en = pwr_reg[PWR_REGUL];
  assign follower_en = pwr_reg[PWR_FOLLOW];
  assign contrast_code = con_reg;
  assign contrast_factor = fac_reg;
  assign ratio_sel = ratio_reg;
  assign ratio_external = rext_reg;

  ////////////////////////////////////////////////////////////////////////////////
  // Display clock: internal oscillator or external clock on the select pin.
  logic cl_s1, cl_s2, cl_s3, cl_lvl_reg, cl_lvl_next, cl_rise;
  logic [11:0] ext_reg, ext_next;
  logic [7:0] osc_reg, osc_next;
  logic [3:0] tick_reg, tick_next;
  logic osc_run, osc_tick, dclk_tick, line_tick, psave;

  assign psave = ctrl_reg[CTRL_PSAVE];
  assign cl_lvl_next = (cl_s2 == cl_s3) ? cl_s3 : cl_lvl_reg;
  assign cl_rise = cl_lvl_next & ~cl_lvl_reg;
  assign ext_act = ext_reg != 12'h000;
  assign osc_run = cl_lvl_reg & ~ext_act & ~psave;
  assign osc_tick = osc_run && osc_reg == 8'(OSC_DIV - 1);
  // An external clock held low gives no edges, so the scan simply stops.
  assign dclk_tick = ~psave & (ext_act ? cl_rise : osc_tick);
  assign line_tick = dclk_tick && tick_reg == (ext_act ? EXT_TICKS_LAST : INT_TICKS_LAST);

  always_comb begin
    ext_next = cl_rise ? 12'(EXT_HOLD) : (ext_act ? ext_reg - 12'h001 : 12'h000);
    osc_next = (!osc_run || osc_tick) ? 8'h00 : osc_reg + 8'h01;
    tick_next = tick_reg;
    if (line_tick) begin
      tick_next = 4'h0;
    end else if (dclk_tick) begin
      tick_next = tick_reg + 4'h1;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      // The select pin idles high for the internal oscillator, so the chain starts
      // high and leaving reset does not look like an external clock edge.
      cl_s1 <= 1'b1;
      cl_s2 <= 1'b1;
      cl_s3 <= 1'b1;
      cl_lvl_reg <= 1'b1;
      ext_reg <= 12'h000;
      osc_reg <= 8'h00;
      tick_reg <= 4'h0;
    end else begin
      cl_s1 <= display_clock_select;
      cl_s2 <= cl_s1;
      cl_s3 <= cl_s2;
      cl_lvl_reg <= cl_lvl_next;
      ext_reg <= ext_next;
      osc_reg <= osc_next;
      tick_reg <= tick_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Line fetch and data latch. The next line is read one column per cycle
  // while the current line is shown, so a line must last over 103 cycles.
  logic [5:0] fline_reg, fline_next, scan_next, laddr;
  logic [6:0] fcnt_reg, fcnt_next, fcol_reg;
  logic fv_reg;
  logic [7:0] fetch_q;
  logic [3:0] fpage;
  logic [2:0] fbit;
  logic [NUM_COLS-1:0] buf_reg, buf_next, lat_reg, lat_next;
  logic fr_next;

  assign laddr = start_reg + fline_reg;
  assign fpage = (fline_reg == LINE_IND) ? PAGE_IND : {1'b0, laddr[5:3]};
  assign fbit = (fline_reg == LINE_IND) ? 3'h0 : laddr[2:0];

  always_ff @(posedge mclk) begin
    if (host_wr && host_addr == OFS_DATA) begin
      mem[{page_reg, col_reg}] <= host_wdata;
    end
    fetch_q <= mem[{fpage, fcnt_reg}];
  end

  always_comb begin
    fline_next = fline_reg;
    fcnt_next = fcnt_reg;
    scan_next = scan_reg;
    lat_next = lat_reg;
    fr_next = fr_reg;
    buf_next = buf_reg;
    if (fv_reg) begin
      buf_next[fcol_reg] = fetch_q[fbit];
    end
    if (fcnt_reg < 7'(NUM_COLS)) begin
      fcnt_next = fcnt_reg + 7'h01;
    end
    if (line_tick) begin
      lat_next = buf_reg;
      scan_next = fline_reg;
      fline_next = (fline_reg == LINE_IND) ? 6'h00 : fline_reg + 6'h01;
      fcnt_next = 7'h00;
      if (scan_reg == LINE_IND) begin
        fr_next = ~fr_reg;
      end
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      fline_reg <= 6'h00;
      fcnt_reg <= 7'(NUM_COLS);
      fcol_reg <= 7'h00;
      fv_reg <= 1'b0;
      scan_reg <= LINE_IND;
      lat_reg <= '0;
      buf_reg <= '0;
      fr_reg <= 1'b0;
    end else begin
      fline_reg <= fline_next;
      fcnt_reg <= fcnt_next;
      fcol_reg <= fcnt_reg;
      fv_reg <= fcnt_reg < 7'(NUM_COLS);
      scan_reg <= scan_next;
      lat_reg <= lat_next;
      buf_reg <= buf_next;
      fr_reg <= fr_next;
    end
  end

  assign frame_alternating_signal = fr_reg;

  ////////////////////////////////////////////////////////////////////////////////
  // Output drivers. Display modes change only what leaves the latch.
  logic disp_on;
  assign disp_on = ctrl_reg[CTRL_DISP_ON];

  genvar gi;
  for (gi = 0; gi < NUM_COLS; gi++) begin : g_seg
    logic pix;
    always_comb begin
      pix = ctrl_reg[CTRL_SEG_REV] ? lat_reg[NUM_COLS-1-gi] : lat_reg[gi];
      pix = disp_on & (ctrl_reg[CTRL_ALL_ON] | (pix ^ ctrl_reg[CTRL_INVERSE]));
    end
    lcd_drv_cell #(.IS_COM(1'b0)) u_seg (
      .mclk(mclk), .rst(rst), .sel(pix), .fr(fr_reg), .psave(psave),
      .level(segment_outputs[gi*DRV_W +: DRV_W])
    );
  end
  for (gi = 0; gi < NUM_COMS; gi++) begin : g_com
    logic hit;
    always_comb begin
      hit = disp_on && scan_reg == 6'(ctrl_reg[CTRL_COM_REV] ? NUM_COMS - 1 - gi : gi);
    end
    lcd_drv_cell #(.IS_COM(1'b1)) u_com (
      .mclk(mclk), .rst(rst), .sel(hit), .fr(fr_reg), .psave(psave),
      .level(common_outputs[gi*DRV_W +: DRV_W])
    );
  end
  lcd_drv_cell #(.IS_COM(1'b1)) u_ind (
    .mclk(mclk), .rst(rst), .sel(disp_on && scan_reg == LINE_IND), .fr(fr_reg),
    .psave(psave), .level(indicator_common)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Checks.
  sequence s_last_access;
    acc && col_reg == COL_LAST && page_reg == PAGE_LAST;
  endsequence
  property p_col_inc;
    @(posedge mclk) disable iff (rst)
    acc && col_reg < COL_LAST |=> col_reg == $past(col_reg) + 7'h01;
  endproperty
  a_col_inc: assert property (p_col_inc) else $error("column did not step");
  property p_col_wrap;
    @(posedge mclk) disable iff (rst)
    acc && col_reg == COL_LAST && page_reg < PAGE_LAST
      |=> col_reg == 7'h00 && page_reg == $past(page_reg) + 4'h1;
  endproperty
  a_col_wrap: assert property (p_col_wrap) else $error("column wrap wrong");
  property p_last_wrap;
    @(posedge mclk) disable iff (rst)
    s_last_access |=> col_reg == 7'h00 && page_reg == 4'h0;
  endproperty
  a_last_wrap: assert property (p_last_wrap) else $error("last address wrap wrong");
  property p_no_ind_step;
    @(posedge mclk) disable iff (rst)
    acc && page_reg != PAGE_IND |=> page_reg != PAGE_IND;
  endproperty
  a_no_ind_step: assert property (p_no_ind_step) else $error("stepped into page 8");
  property p_osc_gate;
    @(posedge mclk) disable iff (rst)
    !cl_lvl_reg || psave |=> osc_reg == 8'h00;
  endproperty
  a_osc_gate: assert property (p_osc_gate) else $error("oscillator ran while off");
  property p_frame;
    @(posedge mclk) disable iff (rst)
    $changed(fr_reg) |-> $past(line_tick) && $past(scan_reg) == LINE_IND;
  endproperty
  a_frame: assert property (p_frame) else $error("frame toggled off boundary");
  property p_line_addr;
    @(posedge mclk) disable iff (rst)
    line_tick && fline_reg != LINE_IND |-> fpage[2:0] == 3'(start_reg + fline_reg >> 3);
  endproperty
  a_line_addr: assert property (p_line_addr) else $error("line address wrong");
  property p_contrast;
    @(posedge mclk) disable iff (rst)
    host_wr && host_addr == OFS_CONTRAST
      |=> contrast_factor == 5'h1F - $past(host_wdata[4:0])
        ##1 ($stable(contrast_factor) || $past(host_wr && host_addr == OFS_CONTRAST));
  endproperty
  a_contrast: assert property (p_contrast) else $error("contrast factor wrong");
  property p_power;
    @(posedge mclk) disable iff (rst)
    host_wr && host_addr == OFS_POWER
      |=> {booster_en, regulator_en, follower_en} == $past(host_wdata[2:0]);
  endproperty
  a_power: assert property (p_power) else $error("power bits wrong");
endmodule
`default_nettype wire

// *** sim/lcd_host_model.sv ***
// Host processor model that drives the register port of the scan block.
`timescale 1ns/100ps
`default_nettype none
module lcd_host_model (
  // Clock
  input wire logic mclk,
  // Register port
  output logic [3:0] host_addr,
  output logic [7:0] host_wdata,
  output logic host_wr,
  output logic host_rd,
  input wire logic [7:0] host_rdata
);
  import lcd_pkg::*;
  initial begin
    host_addr = 4'h0;
    host_wdata = 8'h00;
    host_wr = 1'b0;
    host_rd = 1'b0;
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge mclk);
    host_addr <= a;
    host_wdata <= d;
    host_wr <= 1'b1;
    @(posedge mclk);
    host_wr <= 1'b0;
  endtask
  // Read data stand only in the cycle after the strobe, so it is taken there.
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge mclk);
    host_addr <= a;
    host_rd <= 1'b1;
    @(posedge mclk);
    host_rd <= 1'b0;
    #1;
    d = host_rdata;
  endtask
  // A byte is reached by naming its page first and then its column.
  task automatic go(input logic [3:0] p, input logic [6:0] c);
    wr(OFS_PAGE, {4'h0, p});
    wr(OFS_COL, {1'b0, c});
  endtask
endmodule
`default_nettype wire

// *** sim/lcd_scan_tb.sv ***
// Self-checking testbench for the display addressing and scan block.
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin \
  checked++; \
  if ((a) !== (b)) begin \
    err_count++; \
    $display("wrong value at %0t: %h %h", $time, (a), (b)); \
  end \
end
module lcd_scan_tb;
  import lcd_pkg::*;
  localparam int FR_INT = NUM_LINES * 8 * 16;
  localparam int FR_EXT = NUM_LINES * 16 * 16;
  logic mclk, rst, cl, cl_lvl, ext_on;
  logic [3:0] host_addr, dv;
  logic [7:0] host_wdata, host_rdata, d, s;
  logic host_wr, host_rd, fr, b_en, r_en, f_en, r_ext;
  logic [NUM_COLS*DRV_W-1:0] seg;
  logic [NUM_COMS*DRV_W-1:0] com;
  logic [DRV_W-1:0] ind;
  logic [4:0] c_code, c_fac;
  logic [2:0] r_sel;
  int err_count, checked, cyc;
  lcd_host_model u_host (.mclk(mclk), .host_addr(host_addr), .host_wdata(host_wdata),
    .host_wr(host_wr), .host_rd(host_rd), .host_rdata(host_rdata));
  lcd_scan #(.OSC_DIV(16), .EXT_HOLD(64)) dut (.mclk(mclk), .rst(rst),
    .host_addr(host_addr), .host_wdata(host_wdata), .host_wr(host_wr),
    .host_rd(host_rd), .host_rdata(host_rdata), .display_clock_select(cl),
    .segment_outputs(seg), .common_outputs(com), .indicator_common(ind),
    .frame_alternating_signal(fr), .booster_en(b_en), .regulator_en(r_en),
    .follower_en(f_en), .contrast_code(c_code), .contrast_factor(c_fac),
    .ratio_sel(r_sel), .ratio_external(r_ext));
  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end
  // The external clock has 8 cycles per half so each edge is seen cleanly.
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (ext_on) begin
      dv <= dv + 4'h1;
      if (dv == 4'h7) begin
        cl <= ~cl;
        dv <= 4'h0;
      end
    end else begin
      cl <= cl_lvl;
    end
    if (cyc == 60000) begin
      err_count++;
      finish_test();
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [1:0] lvl(input logic lit, input logic f);
    return lit ? (f ? DRV_HI : DRV_VSS) : (f ? DRV_MIDA : DRV_MIDB);
  endfunction
  function automatic logic [1:0] lvlc(input logic hit, input logic f);
    return hit ? (f ? DRV_VSS : DRV_HI) : (f ? DRV_MIDA : DRV_MIDB);
  endfunction
  task automatic finish_test();
    if (err_count == 0 && checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic wait_fr(output int n);
    logic f;
    n = 0;
    f = fr;
    while (fr === f && n < 20000) begin
      @(posedge mclk);
      #1;
      n++;
    end
  endtask
  task automatic t_reset();
    u_host.rd(OFS_STATUS, d);
    `CHK(d, {2'b00, LINE_IND})
    u_host.rd(4'hF, d);
    `CHK(d, 8'h00)
    `CHK(c_fac, 5'h1F)
    `CHK({b_en, r_en, f_en}, 3'h0)
  endtask
  task automatic t_regs();
    logic [2:0] pw [4] = '{3'h7, 3'h3, 3'h1, 3'h0};
    logic [4:0] cv [4] = '{5'h00, 5'h01, 5'h10, 5'h1F};
    logic [2:0] rv [4] = '{3'h0, 3'h6, 3'h7, 3'h3};
    for (int i = 0; i < 4; i++) begin
      u_host.wr(OFS_POWER, {5'h00, pw[i]});
      u_host.wr(OFS_CONTRAST, {3'h0, cv[i]});
      u_host.wr(OFS_RATIO, {5'h00, rv[i]});
      @(posedge mclk);
      #1;
      `CHK({b_en, r_en, f_en}, pw[i])
      `CHK(c_code, cv[i])
      `CHK(c_fac, 5'h1F - cv[i])
      `CHK(r_sel, rv[i])
      `CHK(r_ext, rv[i] == RATIO_EXT)
    end
    u_host.wr(OFS_START, 8'h1C);
    u_host.rd(OFS_START, d);
    `CHK(d, 8'h1C)
  endtask
  // Only column 0 is lit on every line, so the check needs no line timing.
  task automatic t_seg(input logic [7:0] c);
    logic f, l, o, rv;
    l = c[CTRL_DISP_ON] & (c[CTRL_ALL_ON] | ~c[CTRL_INVERSE]);
    o = c[CTRL_DISP_ON] & (c[CTRL_ALL_ON] | c[CTRL_INVERSE]);
    rv = c[CTRL_SEG_REV];
    u_host.wr(OFS_CTRL, c);
    repeat (300) @(posedge mclk);
    #1 f = fr;
    @(posedge mclk);
    #1;
    if (fr !== f) @(posedge mclk);
    #1 f = fr;
    `CHK(seg[1:0], lvl(rv ? o : l, f))
    `CHK(seg[3:2], lvl(o, f))
    `CHK(seg[203:202], lvl(rv ? l : o, f))
  endtask
  task automatic t_psave();
    u_host.wr(OFS_CTRL, 8'h04 | (8'h01 << CTRL_PSAVE));
    repeat (4) @(posedge mclk);
    #1;
    `CHK({seg, com, ind}, '0)
    u_host.rd(OFS_STATUS, s);
    repeat (300) @(posedge mclk);
    u_host.rd(OFS_STATUS, d);
    `CHK(d, s)
    u_host.wr(OFS_CTRL, 8'h04);
  endtask
  task automatic t_frame(input logic ext, input int exp);
    int n;
    @(posedge mclk);
    ext_on <= ext;
    // Let the mode switch settle; the first frame seen after it is mixed.
    repeat (100) @(posedge mclk);
    #1;
    wait_fr(n);
    wait_fr(n);
    `CHK(n, exp)
    u_host.rd(OFS_STATUS, d);
    `CHK(d[6], ext)
  endtask
  // The scan is frozen here, so the selected common follows the status index.
  task automatic t_com();
    logic [5:0] k;
    u_host.rd(OFS_STATUS, d);
    k = d[5:0];
    for (int r = 0; r < 2; r++) begin
      u_host.wr(OFS_CTRL, 8'h04 | 8'(r << CTRL_COM_REV));
      repeat (2) @(posedge mclk);
      #1;
      for (int j = 0; j < NUM_COMS; j++) begin
        `CHK(com[j*DRV_W +: DRV_W], lvlc(k == 6'(r ? NUM_COMS - 1 - j : j), d[7]))
      end
      `CHK(ind, lvlc(k == LINE_IND, d[7]))
    end
  endtask
  task automatic t_stop();
    @(posedge mclk);
    ext_on <= 1'b0;
    cl_lvl <= 1'b0;
    repeat (200) @(posedge mclk);
    u_host.rd(OFS_STATUS, s);
    repeat (600) @(posedge mclk);
    u_host.rd(OFS_STATUS, d);
    `CHK(d, s)
    `CHK(d[6], 1'b0)
  endtask
  task automatic t_addr();
    u_host.go(4'h7, 7'h64);
    u_host.wr(OFS_DATA, 8'h11);
    u_host.wr(OFS_DATA, 8'h22);
    u_host.wr(OFS_DATA, 8'h33);
    u_host.go(4'h0, 7'h65);
    u_host.wr(OFS_DATA, 8'h44);
    u_host.wr(OFS_DATA, 8'h55);
    u_host.go(4'h8, 7'h65);
    u_host.wr(OFS_DATA, 8'h67);
    u_host.wr(OFS_DATA, 8'h77);
    u_host.go(4'h7, 7'h64);
    u_host.rd(OFS_DATA, d);
    `CHK(d, 8'h11)
    u_host.rd(OFS_DATA, d);
    `CHK(d, 8'h22)
    u_host.rd(OFS_DATA, d);
    `CHK(d, 8'h77)
    u_host.go(4'h0, 7'h65);
    u_host.rd(OFS_DATA, d);
    `CHK(d, 8'h44)
    u_host.rd(OFS_DATA, d);
    `CHK(d, 8'h55)
    u_host.go(4'h8, 7'h65);
    u_host.rd(OFS_DATA, d);
    `CHK(d[0], 1'b1)
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    rst = 1'b1;
    cl = 1'b1;
    cl_lvl = 1'b1;
    ext_on = 1'b0;
    dv = 4'h0;
    cyc = 0;
    err_count = 0;
    checked = 0;
    repeat (6) @(posedge mclk);
    rst <= 1'b0;
    t_reset();
    t_regs();
    u_host.go(4'h0, 7'h00);
    for (int i = 0; i < 918; i++) begin
      if (i == 816) u_host.go(4'h8, 7'h00);
      u_host.wr(OFS_DATA, (i % NUM_COLS == 0) ? 8'hFF : 8'h00);
    end
    t_seg(8'h04);
    t_seg(8'h05);
    t_seg(8'h0C);
    t_seg(8'h14);
    t_seg(8'h00);
    t_psave();
    t_frame(1'b0, FR_INT);
    t_frame(1'b1, FR_EXT);
    t_stop();
    t_com();
    t_addr();
    finish_test();
  end
endmodule
`default_nettype wire
